// [rtl/bstp_port.sv]
// Boundary-scan test port: tap controller, instruction, bypass, id and scan registers.
`timescale 1ns/10ps
// Functional notes
// - Input data sampled on rising test clock.
// - Output data changes on falling test clock.
// - Output data tristated when not shifting.
// - Mode select evaluated on rising edges only.
// - Four test pins, no test reset pin.
// - One-bit bypass register, shortest path.
// - Instruction selects action and data register.
// - Serial input also loads instruction register.
// - Scan register chains all cells serially.
// - Three-bit cell per pin, capture and update.
// - Cell captures core data, enable, pin input.
// - Update stages drive pin data and enable.
// - Every user pin, clocks included, has cell; here only the NUM_CELLS data pins do, core_clk has none.
// - Test and supply pins have no cell.
// - Shift, clock, update made by tap machine.
// - Cell mode comes from instruction decode.
// - Chain runs from serial input to output.
// - Capture never disturbs normal operation.
// - Instruction register is ten bits.
// - Five high mode selects reach reset state.
// - Reset state: normal use, id instruction loaded.
// - Output enable follows shift states at falling edges.
module bstp_port #(
    parameter int                  NUM_CELLS = bstp_pkg::NUM_CELLS_DEF,
    parameter logic [bstp_pkg::ID_W-1:0] ID_VALUE = bstp_pkg::ID_VALUE_DEF
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe_n,
    input  wire logic [NUM_CELLS-1:0] core_output_data,
    input  wire logic [NUM_CELLS-1:0] core_output_enable,
    input  wire logic [NUM_CELLS-1:0] pin_in,
    output logic      [NUM_CELLS-1:0] pin_out,
    output logic      [NUM_CELLS-1:0] pin_oe
);
    import bstp_pkg::*;

    localparam int BSR_W = NUM_CELLS * CELL_W;

    if (NUM_CELLS < 1) begin : g_bad_cells
        $error("NUM_CELLS must be at least one.");
    end

    // Reset synchronisers, one per clock domain.
    logic core_rst_m_q, core_rst_n_q, tck_rst_m_q, tck_rst_n_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_rst_m_q <= 1'b0;
            core_rst_n_q <= 1'b0;
        end else begin
            core_rst_m_q <= 1'b1;
            core_rst_n_q <= core_rst_m_q;
        end
    end

    // Power-up reset of the test domain only; the port itself has no test reset pin.
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            tck_rst_m_q <= 1'b0;
            tck_rst_n_q <= 1'b0;
        end else begin
            tck_rst_m_q <= 1'b1;
            tck_rst_n_q <= tck_rst_m_q;
        end
    end

    // Tap state machine.
    bstp_state_t state_q, state_d;

    always_comb begin
        case (state_q)
            ST_RESET:    state_d = tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_d = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_d = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_d = tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms ? ST_SEL_DR   : ST_IDLE;
            default:     state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Common controls for every register, made by the tap machine.
    wire capture_dr = (state_q == ST_CAP_DR);
    wire shift_dr   = (state_q == ST_SHIFT_DR);
    wire update_dr  = (state_q == ST_UPD_DR);
    wire capture_ir = (state_q == ST_CAP_IR);
    wire shift_ir   = (state_q == ST_SHIFT_IR);
    wire update_ir  = (state_q == ST_UPD_IR);
    wire shifting   = shift_dr | shift_ir;

    // Instruction register: shift stage and active stage.
    logic [IR_W-1:0] ir_sh_q, ir_q;

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (capture_ir) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (shift_ir) begin
            ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
        end
    end

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            ir_q <= IR_IDCODE;
        end else if (state_d == ST_RESET) begin
            ir_q <= IR_IDCODE;
        end else if (update_ir) begin
            ir_q <= ir_sh_q;
        end
    end

    // Instruction decode; unknown codes fall back to the bypass path.
    wire sel_extest = (ir_q == IR_EXTEST);
    wire sel_bsr    = sel_extest | (ir_q == IR_SAMPLE);
    wire sel_id     = (ir_q == IR_IDCODE);
    wire sel_byp    = !sel_bsr && !sel_id;

    // Pin and core values are sampled through two flops on the test clock.
    // The core data is sampled, not handshaken: a capture is a snapshot and may mix edges.
    logic [NUM_CELLS-1:0] od_m_q, od_s_q, oe_m_q, oe_s_q, pi_m_q, pi_s_q;

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            od_m_q <= '0;
            od_s_q <= '0;
            oe_m_q <= '0;
            oe_s_q <= '0;
            pi_m_q <= '0;
            pi_s_q <= '0;
        end else begin
            od_m_q <= core_output_data;
            od_s_q <= od_m_q;
            oe_m_q <= core_output_enable;
            oe_s_q <= oe_m_q;
            pi_m_q <= pin_in;
            pi_s_q <= pi_m_q;
        end
    end

    // Boundary-scan register, one three-bit cell per user pin.
    logic [BSR_W-1:0]     bsr_q, bsr_cap;
    logic [NUM_CELLS-1:0] upd_out_q, upd_oe_q, upd_out_w, upd_oe_w;

    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
        assign bsr_cap[CELL_W*i+CELL_OUT_POS] = od_s_q[i];
        assign bsr_cap[CELL_W*i+CELL_OE_POS]  = oe_s_q[i];
        assign bsr_cap[CELL_W*i+CELL_IN_POS]  = pi_s_q[i];
        assign upd_out_w[i] = bsr_q[CELL_W*i+CELL_OUT_POS];
        assign upd_oe_w[i]  = bsr_q[CELL_W*i+CELL_OE_POS];
    end

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            bsr_q <= '0;
        end else if (sel_bsr && capture_dr) begin
            bsr_q <= bsr_cap;
        end else if (sel_bsr && shift_dr) begin
            bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
        end
    end

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            upd_out_q <= '0;
            upd_oe_q  <= '0;
        end else if (sel_bsr && update_dr) begin
            upd_out_q <= upd_out_w;
            upd_oe_q  <= upd_oe_w;
        end
    end

    // Bypass and identification registers.
    logic            byp_q;
    logic [ID_W-1:0] id_q;

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            byp_q <= 1'b0;
            id_q  <= '0;
        end else begin
            if (sel_byp && capture_dr) begin
                byp_q <= 1'b0;
            end else if (sel_byp && shift_dr) begin
                byp_q <= tdi;
            end
            if (sel_id && capture_dr) begin
                id_q <= ID_VALUE;
            end else if (sel_id && shift_dr) begin
                id_q <= {tdi, id_q[ID_W-1:1]};
            end
        end
    end

    // Serial output selection and falling-edge launch.
    wire dr_bit  = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);
    wire tdo_src = shift_ir ? ir_sh_q[0] : dr_bit;

    always_ff @(negedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tdo      <= tdo_src;
            tdo_oe_n <= !shifting;
        end
    end

    // Crossing to the core clock: mode bit as a level, update data by toggle handshake.
    // The update words hold for many test clocks after the toggle, so they are stable when copied.
    logic                 upd_tgl_q, ext_m_q, ext_s_q, tgl_m_q, tgl_s_q, tgl_d_q;
    logic [NUM_CELLS-1:0] core_out_q, core_oe_q;

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            upd_tgl_q <= 1'b0;
        end else if (sel_bsr && update_dr) begin
            upd_tgl_q <= !upd_tgl_q;
        end
    end

    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            tgl_m_q <= 1'b0;
            tgl_s_q <= 1'b0;
            tgl_d_q <= 1'b0;
        end else begin
            ext_m_q <= sel_extest;
            ext_s_q <= ext_m_q;
            tgl_m_q <= upd_tgl_q;
            tgl_s_q <= tgl_m_q;
            tgl_d_q <= tgl_s_q;
        end
    end

    wire upd_arrive = tgl_s_q ^ tgl_d_q;

    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            core_out_q <= '0;
            core_oe_q  <= '0;
        end else if (upd_arrive) begin
            core_out_q <= upd_out_q;
            core_oe_q  <= upd_oe_q;
        end
    end

    // Pin drivers: functional values unless the scan mode takes the pins.
    wire [NUM_CELLS-1:0] pin_out_d = ext_s_q ? core_out_q : core_output_data;
    wire [NUM_CELLS-1:0] pin_oe_d  = ext_s_q ? core_oe_q  : core_output_enable;

    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= pin_out_d;
            pin_oe  <= pin_oe_d;
        end
    end

    // Helper counter of consecutive high mode-select samples, for checking only.
    logic [2:0] tms_hi_q;

    always_ff @(posedge tck or negedge tck_rst_n_q) begin
        if (!tck_rst_n_q) begin
            tms_hi_q <= 3'h0;
        end else if (!tms) begin
            tms_hi_q <= 3'h0;
        end else if (tms_hi_q < 3'(TMS_RESET_CNT)) begin
            tms_hi_q <= tms_hi_q + 3'h1;
        end
    end

    sequence s_enter_shift_ir;
        state_q == ST_CAP_IR ##1 state_q == ST_SHIFT_IR;
    endsequence

    a_tms_reset_five: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        tms_hi_q == 3'(TMS_RESET_CNT) |-> state_q == ST_RESET)
        else $error("Five high mode selects did not reach the reset state.");

    a_reset_ir_id: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        state_q == ST_RESET |-> ir_q == IR_IDCODE && !sel_extest)
        else $error("Reset state without the identification instruction.");

    a_ir_capture_shift: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        s_enter_shift_ir |-> ir_sh_q == IR_CAPTURE ##1 ir_sh_q[IR_W-1] == $past(tdi))
        else $error("Instruction register did not capture then shift.");

    a_bypass_one_bit: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        shift_dr && sel_byp |=> byp_q == $past(tdi))
        else $error("Bypass bit did not take the serial input.");

    a_bsr_chain_shift: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        shift_dr && sel_bsr |=> bsr_q[BSR_W-1] == $past(tdi) && bsr_q[0] == $past(bsr_q[1]))
        else $error("Scan chain did not shift by one.");

    a_cell_capture_oe: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        capture_dr && sel_bsr |=> bsr_q[CELL_OE_POS] == $past(oe_s_q[0]))
        else $error("Cell did not capture the core output enable.");

    a_update_hold: assert property (@(posedge tck) disable iff (!tck_rst_n_q)
        !update_dr |=> $stable(upd_out_q) && $stable(upd_oe_q))
        else $error("Update stages changed outside the update state.");

    a_tdo_ir_launch: assert property (@(negedge tck) disable iff (!tck_rst_n_q)
        shift_ir |=> tdo == $past(ir_sh_q[0]))
        else $error("Serial output did not follow the instruction register.");

    a_tdo_enable_on: assert property (@(negedge tck) disable iff (!tck_rst_n_q)
        shifting |=> !tdo_oe_n)
        else $error("Serial output not enabled one falling edge after shift entry.");

    a_tdo_float_off: assert property (@(negedge tck) disable iff (!tck_rst_n_q)
        !shifting |=> tdo_oe_n)
        else $error("Serial output driven outside the shift states.");

    a_pins_normal: assert property (@(posedge core_clk) disable iff (!core_rst_n_q)
        !ext_s_q |=> pin_oe == $past(core_output_enable) && pin_out == $past(core_output_data))
        else $error("Pins disturbed while not in the external test mode.");
endmodule : bstp_port

// [pkg/bstp_pkg.sv]
// Constants and types shared by the boundary-scan test port.
package bstp_pkg;
    localparam int          IR_W          = 10;
    localparam int          ID_W          = 32;
    localparam int          NUM_CELLS_DEF = 8;
    localparam int          CELL_W        = 3;
    localparam int          TMS_RESET_CNT = 5;
    // Cell bit positions inside one three-bit cell, nearest the output first.
    localparam int          CELL_OUT_POS  = 0;
    localparam int          CELL_OE_POS   = 1;
    localparam int          CELL_IN_POS   = 2;
    // Instruction codes; the identification read is the value after reset.
    localparam logic [9:0]  IR_IDCODE     = 10'h006;
    localparam logic [9:0]  IR_SAMPLE     = 10'h005;
    localparam logic [9:0]  IR_EXTEST     = 10'h00F;
    localparam logic [9:0]  IR_BYPASS     = 10'h3FF;
    localparam logic [9:0]  IR_CAPTURE    = 10'h001;
    // The identification value is arbitrary and names no maker.
    localparam logic [31:0] ID_VALUE_DEF  = 32'h0000_A001;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bstp_state_t;
endpackage : bstp_pkg

// [test/bstp_jtag_ctrl.sv]
// Behavioural model of the external test controller that drives three of the four test pins and reads the serial output.
`timescale 1ns/10ps
module bstp_jtag_ctrl (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    localparam realtime HALF = 62.5;

    // The test clock rests low between calls, as the pull-down on the pin would leave it.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; mode and data change while the clock is low.
    task automatic pulse(input logic m, input logic d, output logic q, output logic oe_n);
        tms <= m;
        tdi <= d;
        #(HALF);
        tck = 1'b1;
        // A released output has no pull, so it shows the inverse of its last level and stale bits cannot pass.
        q = tdo_oe_n ? !tdo : tdo;
        oe_n = tdo_oe_n;
        #(HALF);
        tck = 1'b0;
    endtask : pulse

    task automatic run(input logic m, input int n);
        logic q;
        logic oe_n;
        for (int i = 0; i < n; i++) begin
            pulse(m, 1'b1, q, oe_n);
        end
    endtask : run

    // Six high mode selects, one more than needed, then one low to rest in idle.
    task automatic tap_reset();
        run(1'b1, 6);
        run(1'b0, 1);
    endtask : tap_reset

    // Full scan from idle back to idle; oe_ok tells that the output was driven on every shift bit and released on the bits just before and after.
    task automatic scan(input logic ir, input int len, input logic [63:0] din,
                        output logic [63:0] dout, output logic oe_ok);
        logic q;
        logic oe_n;
        dout = '0;
        oe_ok = 1'b1;
        pulse(1'b1, 1'b1, q, oe_n);
        if (ir) begin
            pulse(1'b1, 1'b1, q, oe_n);
        end
        pulse(1'b0, 1'b1, q, oe_n);
        pulse(1'b0, 1'b1, q, oe_n);
        oe_ok &= oe_n;
        for (int i = 0; i < len; i++) begin
            pulse(i == len - 1, din[i], q, oe_n);
            dout[i] = q;
            oe_ok &= ~oe_n;
        end
        pulse(1'b1, 1'b1, q, oe_n);
        oe_ok &= oe_n;
        pulse(1'b0, 1'b1, q, oe_n);
    endtask : scan
endmodule : bstp_jtag_ctrl

// [test/bstp_port_tb.sv]
// Self-checking testbench for the boundary-scan test port.
`timescale 1ns/10ps
module bstp_port_tb;
    import bstp_pkg::*;
    localparam int N = NUM_CELLS_DEF;
    localparam logic [23:0] PRE = 24'h5AC396;
    localparam logic [23:0] UPD = 24'hA53C69;

    logic           core_clk;
    logic           reset_n;
    logic           tck;
    logic           tms;
    logic           tdi;
    logic           tdo;
    logic           tdo_oe_n;
    logic [N-1:0]   core_output_data;
    logic [N-1:0]   core_output_enable;
    logic [N-1:0]   pin_in;
    logic [N-1:0]   pin_out;
    logic [N-1:0]   pin_oe;
    logic [63:0]    dout;
    logic           oe_ok;
    int             num_errors;
    int             comparisons;

    bstp_port #(.NUM_CELLS(N)) i_bstp_port (
        .core_clk(core_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .core_output_data(core_output_data), .core_output_enable(core_output_enable),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
    );

    bstp_jtag_ctrl i_bstp_jtag_ctrl (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n)
    );

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic t_idcode();
        i_bstp_jtag_ctrl.scan(1'b0, 32, 64'h0, dout, oe_ok);
        check_val(dout[31:0], ID_VALUE_DEF, "id read");
        check_val(oe_ok, 1'b1, "tdo enable window");
        check_val(tdo_oe_n, 1'b1, "tdo idle");
        $display("Test idcode done");
    endtask : t_idcode

    // A known and an unknown code both leave the one-bit path behind.
    task automatic t_bypass();
        logic [9:0] codes [2];
        codes = '{IR_BYPASS, 10'h155};
        foreach (codes[k]) begin
            i_bstp_jtag_ctrl.scan(1'b1, 10, {54'h0, codes[k]}, dout, oe_ok);
            check_val(dout[9:0], 10'h001, "ir capture");
            i_bstp_jtag_ctrl.scan(1'b0, 8, 64'hA5, dout, oe_ok);
            check_val(dout[7:0], 8'h4A, "bypass delay");
            check_val(oe_ok, 1'b1, "tdo enable window");
        end
        $display("Test bypass done");
    endtask : t_bypass

    task automatic t_sample();
        logic [23:0] exp;
        @(posedge core_clk);
        core_output_data   <= 8'h3C;
        core_output_enable <= 8'h96;
        pin_in             <= 8'hF0;
        i_bstp_jtag_ctrl.run(1'b0, 3);
        for (int i = 0; i < N; i++) begin
            exp[3*i+CELL_OUT_POS] = core_output_data[i];
            exp[3*i+CELL_OE_POS]  = core_output_enable[i];
            exp[3*i+CELL_IN_POS]  = pin_in[i];
        end
        i_bstp_jtag_ctrl.scan(1'b1, 10, {54'h0, IR_SAMPLE}, dout, oe_ok);
        i_bstp_jtag_ctrl.scan(1'b0, 24, {40'h0, PRE}, dout, oe_ok);
        check_val(dout[23:0], exp, "sample capture");
        check_val(pin_out, core_output_data, "pins functional");
        check_val(pin_oe, core_output_enable, "enables functional");
        $display("Test sample done");
    endtask : t_sample

    task automatic t_extest();
        logic [N-1:0] eo;
        logic [N-1:0] ee;
        i_bstp_jtag_ctrl.scan(1'b1, 10, {54'h0, IR_EXTEST}, dout, oe_ok);
        i_bstp_jtag_ctrl.run(1'b0, 1);
        for (int i = 0; i < N; i++) begin
            eo[i] = PRE[3*i+CELL_OUT_POS];
            ee[i] = PRE[3*i+CELL_OE_POS];
        end
        check_val(pin_out, eo, "preloaded pin data");
        check_val(pin_oe, ee, "preloaded pin enable");
        i_bstp_jtag_ctrl.scan(1'b0, 24, {40'h0, UPD}, dout, oe_ok);
        i_bstp_jtag_ctrl.run(1'b0, 1);
        for (int i = 0; i < N; i++) begin
            eo[i] = UPD[3*i+CELL_OUT_POS];
            ee[i] = UPD[3*i+CELL_OE_POS];
        end
        check_val(pin_out, eo, "updated pin data");
        check_val(pin_oe, ee, "updated pin enable");
        i_bstp_jtag_ctrl.tap_reset();
        check_val(pin_out, core_output_data, "pins after tap reset");
        check_val(pin_oe, core_output_enable, "enables after tap reset");
        t_idcode();
        $display("Test extest done");
    endtask : t_extest

    // Cuts a hung run short; the whole sequence needs well under this.
    initial begin
        #100us;
        num_errors++;
        $display("Error at %0t: run did not finish in time", $time);
        conclude();
    end

    initial begin
        reset_n            = 1'b0;
        core_output_data   = '0;
        core_output_enable = '0;
        pin_in             = '0;
        num_errors         = 0;
        comparisons        = 0;
        // The odd offset keeps the test clock out of phase with the core clock.
        #3.3;
        i_bstp_jtag_ctrl.run(1'b1, 2);
        @(posedge core_clk);
        reset_n <= 1'b1;
        i_bstp_jtag_ctrl.tap_reset();
        check_val(pin_out, core_output_data, "pins after reset");
        check_val(pin_oe, core_output_enable, "enables after reset");
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        conclude();
    end
endmodule : bstp_port_tb
